/* File: pkg/scs_pkg.sv */
package scs_pkg;
   localparam int unsigned CLK_HZ            = 125000000;
   localparam int unsigned T_CAL_LED_MS      = 300;
   localparam int unsigned T_CFG_ALARM_MS    = 300;
   localparam int unsigned T_PULSE_PERIOD_MS = 1200;
   localparam int unsigned T_PULSE_ON_MS     = 50;
   localparam int unsigned T_CAL_RUN_MS      = 12000;
   localparam int unsigned T_BLINK_HALF_MS   = 500;
   localparam int unsigned MS_CYC            = CLK_HZ / 1000;
   localparam int unsigned CAL_LED_CYC       = T_CAL_LED_MS * MS_CYC;
   localparam int unsigned CFG_ALARM_CYC     = T_CFG_ALARM_MS * MS_CYC;
   localparam int unsigned PULSE_PERIOD_CYC  = T_PULSE_PERIOD_MS * MS_CYC;
   localparam int unsigned PULSE_ON_CYC      = T_PULSE_ON_MS * MS_CYC;
   localparam int unsigned CAL_RUN_CYC       = T_CAL_RUN_MS * MS_CYC;
   localparam int unsigned BLINK_HALF_CYC    = T_BLINK_HALF_MS * MS_CYC;

   localparam logic [3:0] SW_SERVICE_POS = 4'h9;

   // Register byte addresses
   localparam logic [7:0] A_CTRL   = 8'h00;
   localparam logic [7:0] A_PARAM  = 8'h04;
   localparam logic [7:0] A_STATUS = 8'h08;
   localparam logic [7:0] A_NODE   = 8'h0C;
   localparam logic [7:0] A_CALRES = 8'h10;
   localparam logic [7:0] A_SVC    = 8'h14;

   // CTRL fields
   localparam int CTL_CAL_START = 0;
   localparam int CTL_HEAT      = 1;
   localparam int CTL_BUS_ACT   = 2;
   localparam int CTL_SP_LSB    = 16;
   localparam int SP_W          = 10;
   // PARAM fields
   localparam int PAR_VALID     = 4;
   // STATUS fields
   localparam int ST_CTRL_ACT   = 0;
   localparam int ST_ALARM      = 3;
   localparam int ST_CAL_ACT    = 5;
   localparam int ST_CAL_OK     = 8;
   localparam int ST_SEL_LSB    = 12;
   localparam int ST_ERR_LSB    = 16;
   // CALRES fields
   localparam int CR_DONE       = 0;
   localparam int CR_V_BAD      = 1;
   localparam int CR_I_BAD      = 2;
   // SVC fields
   localparam int SVC_CHANGED   = 4;

   localparam logic [7:0]  ERR_NONE   = 8'h00;
   localparam logic [7:0]  ERR_V_RNG  = 8'h11;
   localparam logic [7:0]  ERR_I_RNG  = 8'h12;
   localparam logic [7:0]  ERR_TMO    = 8'h13;
   localparam logic [31:0] RD_ZERO    = 32'h0000_0000;
   localparam logic [1:0]  RESP_OKAY  = 2'b00;
   localparam logic [1:0]  RESP_SLVERR = 2'b10;

   typedef enum logic [4:0]
   {
      ST_BOOT    = 5'b00001,
      ST_IDLE    = 5'b00010,
      ST_CAL     = 5'b00100,
      ST_FAIL    = 5'b01000,
      ST_HEAT    = 5'b10000
   } scs_state_t;
endpackage

/* File: pkg/scs_led_if.sv */
`timescale 1ns/1ns
interface scs_led_if;
   logic boot_win;
   logic cfg_win;
   logic pulse;
   logic blink;
   modport gen (output boot_win, output cfg_win, output pulse, output blink);
   modport use_ (input boot_win, input cfg_win, input pulse, input blink);
endinterface

/* File: rtl/scs_timebase.sv */
`timescale 1ns/1ns
module scs_timebase
   import scs_pkg::*;
#(
   parameter int unsigned CAL_LED_N   = CAL_LED_CYC,
   parameter int unsigned CFG_ALARM_N = CFG_ALARM_CYC,
   parameter int unsigned PERIOD_N    = PULSE_PERIOD_CYC,
   parameter int unsigned PULSE_N     = PULSE_ON_CYC,
   parameter int unsigned BLINK_N     = BLINK_HALF_CYC
)
(
   input  wire logic aclk,    // Clock
   input  wire logic aresetn, // Sync reset
   input  wire logic ce,      // Clock enable
   scs_led_if.gen    t        // Timing strobes
);
   logic [31:0] boot_reg;
   logic [31:0] per_reg;
   logic [31:0] blk_reg;
   logic        blink_reg;

   always_ff @(posedge aclk)
      if (!aresetn)
         boot_reg <= '0;
      else if (ce && boot_reg < CFG_ALARM_N)
         boot_reg <= boot_reg + 32'd1;

   always_ff @(posedge aclk)
      if (!aresetn)
         per_reg <= '0;
      else if (ce)
         per_reg <= (per_reg >= PERIOD_N - 1) ? '0 : per_reg + 32'd1;

   always_ff @(posedge aclk)
      if (!aresetn)
      begin
         blk_reg   <= '0;
         blink_reg <= 1'b0;
      end
      else if (ce)
      begin
         if (blk_reg >= BLINK_N - 1)
         begin
            blk_reg   <= '0;
            blink_reg <= ~blink_reg;
         end
         else
            blk_reg <= blk_reg + 32'd1;
      end

   assign t.boot_win = boot_reg < CAL_LED_N;
   assign t.cfg_win  = boot_reg < CFG_ALARM_N;
   assign t.pulse    = per_reg < PULSE_N;
   assign t.blink    = blink_reg;
endmodule

/* File: rtl/scs_seq.sv */
`timescale 1ns/1ns
module scs_seq
   import scs_pkg::*;
#(
   parameter int unsigned CAL_RUN_N = CAL_RUN_CYC,
   parameter int unsigned CAL_LED_N = CAL_LED_CYC,
   parameter int unsigned CFG_AL_N  = CFG_ALARM_CYC,
   parameter int unsigned PERIOD_N  = PULSE_PERIOD_CYC,
   parameter int unsigned PULSE_N   = PULSE_ON_CYC,
   parameter int unsigned BLINK_N   = BLINK_HALF_CYC
)
(
   input  wire logic        aclk,          // Clock 125 MHz
   input  wire logic        aresetn,       // Sync reset, power-up
   input  wire logic        ce,            // Clock enable
   input  wire logic [7:0]  node_sw,       // Node id rotary pair
   input  wire logic [3:0]  range_sw,      // Range/alloy rotary
   input  wire logic [3:0]  svc_sel,       // Service-software selection
   input  wire logic        svc_changed,   // Config altered by service tool
   input  wire logic [31:0] s_axi_awaddr,  // AXI write address
   input  wire logic        s_axi_awvalid, // AXI
   output logic             s_axi_awready, // AXI
   input  wire logic [31:0] s_axi_wdata,   // AXI write data
   input  wire logic [3:0]  s_axi_wstrb,   // AXI byte strobes
   input  wire logic        s_axi_wvalid,  // AXI
   output logic             s_axi_wready,  // AXI
   output logic [1:0]       s_axi_bresp,   // AXI
   output logic             s_axi_bvalid,  // AXI
   input  wire logic        s_axi_bready,  // AXI
   input  wire logic [31:0] s_axi_araddr,  // AXI read address
   input  wire logic        s_axi_arvalid, // AXI
   output logic             s_axi_arready, // AXI
   output logic [31:0]      s_axi_rdata,   // AXI read data
   output logic [1:0]       s_axi_rresp,   // AXI
   output logic             s_axi_rvalid,  // AXI
   input  wire logic        s_axi_rready,  // AXI
   output logic             cal_led,       // Calibration LED
   output logic             alarm_led,     // Alarm LED
   output logic             output_led,    // Output LED
   output logic             heat_led,      // Heat LED
   output logic             fieldbus_run_led,   // Bus run LED
   output logic             fieldbus_fault_led, // Bus fault LED
   output logic [15:0]      node_id        // Adopted node id
);
   scs_led_if tb_if ();

   scs_timebase #(
      .CAL_LED_N   (CAL_LED_N),
      .CFG_ALARM_N (CFG_AL_N),
      .PERIOD_N    (PERIOD_N),
      .PULSE_N     (PULSE_N),
      .BLINK_N     (BLINK_N)
   ) u_tb (
      .aclk    (aclk),
      .aresetn (aresetn),
      .ce      (ce),
      .t       (tb_if.gen)
   );

   function automatic logic [31:0] wmerge(input logic [31:0] old_v, input logic [31:0] new_v,
                                          input logic [3:0] be);
      logic [31:0] r;
      r = old_v;
      for (int i = 0; i < 4; i++)
         if (be[i])
            r[i*8 +: 8] = new_v[i*8 +: 8];
      return r;
   endfunction

   function automatic logic mapped(input logic [7:0] a);
      return a == A_CTRL || a == A_PARAM || a == A_STATUS || a == A_NODE
          || a == A_CALRES || a == A_SVC;
   endfunction

   scs_state_t  state_reg;
   logic [31:0] ctrl_reg;
   logic [31:0] param_reg;
   logic [31:0] calres_reg;
   logic [31:0] cnt_reg;
   logic [7:0]  err_reg;
   logic        cal_act_reg;
   logic        cal_ok_reg;
   logic        alarm_reg;
   logic        ctrl_act_reg;
   logic        node_done_reg;
   logic [7:0]  aw_addr_reg;
   logic        aw_have_reg;
   logic [31:0] w_data_reg;
   logic [3:0]  w_strb_reg;
   logic        w_have_reg;
   logic [3:0]  sel_range;
   logic        wr_fire;
   logic        wr_ok;
   logic        cal_start_edge;
   logic        cal_start_q;

   // Parameter value wins over switch; position 9 defers to service tool
   always_comb
      if (param_reg[PAR_VALID])
         sel_range = param_reg[3:0];
      else if (range_sw == SW_SERVICE_POS)
         sel_range = svc_sel;
      else
         sel_range = range_sw;

   // Node id switches are read once; later changes need a power cycle
   always_ff @(posedge aclk)
      if (!aresetn)
      begin
         node_id       <= 16'h0000;
         node_done_reg <= 1'b0;
      end
      else if (ce && !node_done_reg)
      begin
         node_id       <= {8'h00, node_sw};
         node_done_reg <= 1'b1;
      end

   // AXI write channel: address and data accepted in either order
   assign wr_fire = aw_have_reg && w_have_reg && !s_axi_bvalid;
   assign wr_ok   = wr_fire && mapped(aw_addr_reg);

   always_ff @(posedge aclk)
      if (!aresetn)
      begin
         aw_have_reg   <= 1'b0;
         w_have_reg    <= 1'b0;
         aw_addr_reg   <= 8'h00;
         w_data_reg    <= RD_ZERO;
         w_strb_reg    <= 4'h0;
         s_axi_awready <= 1'b0;
         s_axi_wready  <= 1'b0;
         s_axi_bvalid  <= 1'b0;
         s_axi_bresp   <= RESP_OKAY;
      end
      else if (ce)
      begin
         s_axi_awready <= !aw_have_reg && !s_axi_awready;
         s_axi_wready  <= !w_have_reg && !s_axi_wready;
         if (s_axi_awvalid && s_axi_awready)
         begin
            aw_have_reg <= 1'b1;
            aw_addr_reg <= s_axi_awaddr[7:0];
         end
         if (s_axi_wvalid && s_axi_wready)
         begin
            w_have_reg <= 1'b1;
            w_data_reg <= s_axi_wdata;
            w_strb_reg <= s_axi_wstrb;
         end
         if (wr_fire)
         begin
            aw_have_reg  <= 1'b0;
            w_have_reg   <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= mapped(aw_addr_reg) ? RESP_OKAY : RESP_SLVERR;
         end
         else if (s_axi_bvalid && s_axi_bready)
            s_axi_bvalid <= 1'b0;
      end

   always_ff @(posedge aclk)
      if (!aresetn)
      begin
         ctrl_reg   <= RD_ZERO;
         param_reg  <= RD_ZERO;
         calres_reg <= RD_ZERO;
      end
      else if (ce && wr_ok)
         unique case (aw_addr_reg)
            A_CTRL:   ctrl_reg   <= wmerge(ctrl_reg, w_data_reg, w_strb_reg);
            A_PARAM:  param_reg  <= wmerge(param_reg, w_data_reg, w_strb_reg);
            A_CALRES: calres_reg <= wmerge(calres_reg, w_data_reg, w_strb_reg);
            default:  ;
         endcase

   // AXI read channel
   always_ff @(posedge aclk)
      if (!aresetn)
      begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid  <= 1'b0;
         s_axi_rdata   <= RD_ZERO;
         s_axi_rresp   <= RESP_OKAY;
      end
      else if (ce)
      begin
         // Ready pulses on its own, so a master that holds arvalid is always served
         s_axi_arready <= !s_axi_rvalid && !s_axi_arready;
         if (s_axi_arvalid && s_axi_arready)
         begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b1;
            s_axi_rresp   <= mapped(s_axi_araddr[7:0]) ? RESP_OKAY : RESP_SLVERR;
            unique case (s_axi_araddr[7:0])
               A_CTRL:   s_axi_rdata <= ctrl_reg;
               A_PARAM:  s_axi_rdata <= param_reg;
               A_STATUS: s_axi_rdata <= {8'h00, err_reg, sel_range, 3'b000, cal_ok_reg,
                                         2'b00, cal_act_reg, 1'b0, alarm_reg,
                                         2'b00, ctrl_act_reg};
               A_NODE:   s_axi_rdata <= {16'h0000, node_id};
               A_CALRES: s_axi_rdata <= calres_reg;
               A_SVC:    s_axi_rdata <= {27'h0, svc_changed, svc_sel};
               default:  s_axi_rdata <= RD_ZERO;
            endcase
         end
         else if (s_axi_rvalid && s_axi_rready)
            s_axi_rvalid <= 1'b0;
      end

   assign cal_start_edge = ctrl_reg[CTL_CAL_START] && !cal_start_q;

   always_ff @(posedge aclk)
      if (!aresetn)
         cal_start_q <= 1'b0;
      else if (ce)
         cal_start_q <= ctrl_reg[CTL_CAL_START];

   // Sequencer. Range selection itself is analogue; here the front end reports
   // its verdict through CALRES once the run window has elapsed.
   always_ff @(posedge aclk)
      if (!aresetn)
      begin
         state_reg    <= ST_BOOT;
         cnt_reg      <= '0;
         cal_act_reg  <= 1'b0;
         cal_ok_reg   <= 1'b0;
         alarm_reg    <= 1'b0;
         ctrl_act_reg <= 1'b0;
         err_reg      <= ERR_NONE;
      end
      else if (ce)
         unique case (state_reg)
            ST_BOOT:
               if (!tb_if.cfg_win)
                  state_reg <= ST_IDLE;
            ST_IDLE, ST_FAIL:
               if (cal_start_edge)
               begin
                  state_reg   <= ST_CAL;
                  cnt_reg     <= '0;
                  cal_act_reg <= 1'b1;
                  cal_ok_reg  <= 1'b0;
                  alarm_reg   <= 1'b0;
                  err_reg     <= ERR_NONE;
               end
               else if (state_reg == ST_IDLE && cal_ok_reg && ctrl_reg[CTL_HEAT]
                        && ctrl_reg[CTL_SP_LSB +: SP_W] != '0)
               begin
                  state_reg    <= ST_HEAT;
                  ctrl_act_reg <= 1'b1;
               end
            ST_CAL:
               if (cnt_reg < CAL_RUN_N - 1)
                  cnt_reg <= cnt_reg + 32'd1;
               else if (calres_reg[CR_DONE])
               begin
                  cal_act_reg <= 1'b0;
                  if (calres_reg[CR_V_BAD] || calres_reg[CR_I_BAD])
                  begin
                     state_reg <= ST_FAIL;
                     alarm_reg <= 1'b1;
                     err_reg   <= calres_reg[CR_V_BAD] ? ERR_V_RNG : ERR_I_RNG;
                  end
                  else
                  begin
                     state_reg  <= ST_IDLE;
                     cal_ok_reg <= 1'b1;
                  end
               end
               else if (cnt_reg < 2 * CAL_RUN_N)
                  cnt_reg <= cnt_reg + 32'd1;
               else
               begin
                  state_reg   <= ST_FAIL;
                  cal_act_reg <= 1'b0;
                  alarm_reg   <= 1'b1;
                  err_reg     <= ERR_TMO;
               end
            ST_HEAT:
               if (!ctrl_reg[CTL_HEAT])
               begin
                  state_reg    <= ST_IDLE;
                  ctrl_act_reg <= 1'b0;
               end
            default:
               state_reg <= ST_BOOT;
         endcase

   // LED drive, all registered
   always_ff @(posedge aclk)
      if (!aresetn)
      begin
         cal_led            <= 1'b0;
         alarm_led          <= 1'b0;
         output_led         <= 1'b0;
         heat_led           <= 1'b0;
         fieldbus_run_led   <= 1'b0;
         fieldbus_fault_led <= 1'b0;
      end
      else if (ce)
      begin
         cal_led    <= (state_reg == ST_BOOT && tb_if.boot_win)
                    || state_reg == ST_CAL;
         alarm_led  <= (state_reg == ST_BOOT && svc_changed)
                    || (state_reg == ST_FAIL && tb_if.blink);
         output_led <= state_reg == ST_IDLE && tb_if.pulse;
         heat_led   <= state_reg == ST_HEAT;
         fieldbus_run_led   <= ctrl_reg[CTL_BUS_ACT];
         fieldbus_fault_led <= 1'b0;
      end
endmodule

/* File: bench/scs_seq_asserts.sv */
`timescale 1ns/1ns
module scs_seq_asserts
   import scs_pkg::*;
#(
   parameter int unsigned PULSE_N = PULSE_ON_CYC,
   parameter int unsigned BLINK_N = BLINK_HALF_CYC
)
(
   input wire logic        aclk,               // Clock
   input wire logic        aresetn,            // Sync reset
   input wire logic        cal_led,            // Calibration LED
   input wire logic        alarm_led,          // Alarm LED
   input wire logic        output_led,         // Output LED
   input wire logic        heat_led,           // Heat LED
   input wire logic        fieldbus_fault_led, // Bus fault LED
   input wire logic [15:0] node_id             // Node id
);
   localparam int MAXW = 400;
   int unsigned hi_run;
   int unsigned al_run;
   int unsigned up_cnt;

   default clocking cb @(posedge aclk);
   endclocking
   default disable iff (!aresetn);

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         hi_run <= 0;
         al_run <= 0;
         up_cnt <= 0;
      end
      else
      begin
         hi_run <= output_led ? hi_run + 1 : 0;
         al_run <= alarm_led ? al_run + 1 : 0;
         // Saturates so the warm-up gate never wraps
         if (up_cnt < 255)
            up_cnt <= up_cnt + 1;
      end
   end

   sequence s_cal_on;
      $rose(cal_led);
   endsequence

   // A pulse cut short by a mode change is not a pulse fault; the look-back
   // skips the first pulse after calibration or heating, which may start mid-period
   sequence s_pulse_end;
      $fell(output_led) && !cal_led && !heat_led
         && !$past(cal_led, PULSE_N) && !$past(heat_led, PULSE_N);
   endsequence

   chk_node_upper: assert property (node_id[15:8] == 8'h00)
      else $error("node id upper byte not zero");
   chk_node_fixed: assert property (up_cnt >= 8 |-> $stable(node_id))
      else $error("node id changed while running");
   chk_cal_lit: assert property (s_cal_on |-> cal_led [*8])
      else $error("calibration LED pulse too short");
   chk_cal_ends: assert property (s_cal_on |-> ##[1:MAXW] !cal_led)
      else $error("calibration LED never went out");
   chk_fault_dark: assert property (!fieldbus_fault_led)
      else $error("bus fault LED lit");
   chk_pulse_len: assert property (s_pulse_end |-> hi_run == PULSE_N)
      else $error("output LED pulse length wrong");
   // The first blink after a failed run may start mid-phase, so it is skipped
   chk_blink_half: assert property
      ($fell(alarm_led) && !cal_led && !$past(cal_led, BLINK_N) && up_cnt >= 150
         |-> al_run == BLINK_N)
      else $error("alarm blink half period wrong");
   chk_heat_clean: assert property (heat_led |-> !cal_led && !alarm_led)
      else $error("heat LED lit outside calibrated state");
endmodule

/* File: bench/scs_fb_master.sv */
`timescale 1ns/1ns
module scs_fb_master
(
   input  wire logic        aclk,          // Clock
   output logic [31:0]      s_axi_awaddr,  // AXI
   output logic             s_axi_awvalid, // AXI
   input  wire logic        s_axi_awready, // AXI
   output logic [31:0]      s_axi_wdata,   // AXI
   output logic [3:0]       s_axi_wstrb,   // AXI
   output logic             s_axi_wvalid,  // AXI
   input  wire logic        s_axi_wready,  // AXI
   input  wire logic [1:0]  s_axi_bresp,   // AXI
   input  wire logic        s_axi_bvalid,  // AXI
   output logic             s_axi_bready,  // AXI
   output logic [31:0]      s_axi_araddr,  // AXI
   output logic             s_axi_arvalid, // AXI
   input  wire logic        s_axi_arready, // AXI
   input  wire logic [31:0] s_axi_rdata,   // AXI
   input  wire logic [1:0]  s_axi_rresp,   // AXI
   input  wire logic        s_axi_rvalid,  // AXI
   output logic             s_axi_rready   // AXI
);
   // Output words sit at zero before the controller powers up
   initial {s_axi_awaddr, s_axi_awvalid, s_axi_wdata, s_axi_wstrb, s_axi_wvalid, s_axi_bready,
            s_axi_araddr, s_axi_arvalid, s_axi_rready} = '0;

   task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
      @(posedge aclk);
      s_axi_awaddr  <= {24'h00_0000, a};
      s_axi_wdata   <= d;
      s_axi_wstrb   <= 4'hF;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid  <= 1'b1;
      s_axi_bready  <= 1'b1;
      do
      begin
         @(posedge aclk);
         if (s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wready) s_axi_wvalid <= 1'b0;
      end
      while (!s_axi_bvalid);
      s_axi_bready <= 1'b0;
      r = s_axi_bresp;
   endtask

   task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
      @(posedge aclk);
      s_axi_araddr  <= {24'h00_0000, a};
      s_axi_arvalid <= 1'b1;
      s_axi_rready  <= 1'b1;
      do
      begin
         @(posedge aclk);
         if (s_axi_arready) s_axi_arvalid <= 1'b0;
      end
      while (!s_axi_rvalid);
      s_axi_rready <= 1'b0;
      d = s_axi_rdata;
      r = s_axi_rresp;
   endtask
endmodule

/* File: bench/scs_seq_tb.sv */
`timescale 1ns/1ns
module scs_seq_tb;
   import scs_pkg::*;
   localparam int CRN = 60;
   localparam int CLN = 40;
   localparam int CAN = 40;
   localparam int PRN = 100;
   localparam int BLN = 30;
   localparam int LIMIT = 20000;
   logic        aclk = 1'b0;
   logic        aresetn, ce, svc_changed;
   logic [7:0]  node_sw;
   logic [3:0]  range_sw, svc_sel, pv, s_axi_wstrb;
   logic [31:0] s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_rdata, st;
   logic [1:0]  s_axi_bresp, s_axi_rresp, rr;
   logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
   logic        s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
   logic        cal_led, alarm_led, output_led, heat_led, fieldbus_run_led, fieldbus_fault_led;
   logic [15:0] node_id, exp_node;
   logic [9:0]  sp;
   int          mismatches = 0;
   int          n_checks = 0;
   int          cyc = 0;
   int          k, a, b;
   logic [31:0] vd [4] = '{32'h3, 32'h5, 32'h7, 32'h0};
   logic [7:0]  ve [4] = '{ERR_V_RNG, ERR_I_RNG, ERR_V_RNG, ERR_TMO};

   always #4 aclk = ~aclk;

   scs_fb_master u_scs_fb_master (
      .aclk, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
      .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
      .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready
   );

   scs_seq #(
      .CAL_RUN_N(CRN), .CAL_LED_N(CLN), .CFG_AL_N(CAN), .PERIOD_N(PRN), .PULSE_N(20),
      .BLINK_N(BLN)
   ) u_scs_seq (
      .aclk, .aresetn, .ce, .node_sw, .range_sw, .svc_sel, .svc_changed,
      .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
      .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
      .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
      .cal_led, .alarm_led, .output_led, .heat_led, .fieldbus_run_led, .fieldbus_fault_led,
      .node_id
   );

   task automatic close_out;
      $display("checks %0d mismatches %0d", n_checks, mismatches);
      if (mismatches == 0 && n_checks > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask

   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      n_checks++;
      if (seen !== exp)
      begin
         mismatches++;
         $display("ERROR %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task automatic wr(input logic [7:0] ad, input logic [31:0] d);
      u_scs_fb_master.wr(ad, d, rr);
      check("bresp", 32'(rr), 32'(RESP_OKAY));
   endtask

   task automatic rd(input logic [7:0] ad);
      u_scs_fb_master.rd(ad, st, rr);
   endtask

   task automatic wait_lvl(input logic v, output int n);
      n = 0;
      while (output_led !== v && n < 400)
      begin
         @(posedge aclk);
         n++;
      end
   endtask

   task automatic run_cal(input logic [31:0] v, input logic [7:0] e);
      int t0;
      wr(A_CALRES, 32'h0);
      wr(A_CTRL, 32'h4);
      wr(A_CTRL, 32'h5);
      t0 = cyc;
      repeat (3) @(posedge aclk);
      check("cal_led on", 32'(cal_led), 32'h1);
      rd(A_STATUS);
      check("cal active", 32'(st[ST_CAL_ACT]), 32'h1);
      if (v != 0)
         wr(A_CALRES, v);
      k = 0;
      while (cal_led !== 1'b0 && k < 400)
      begin
         @(posedge aclk);
         k++;
      end
      check("cal length", 32'(cyc - t0 >= CRN), 32'h1);
      check("cal led off", 32'(cal_led), 32'h0);
      rd(A_STATUS);
      check("cal active end", 32'(st[ST_CAL_ACT]), 32'h0);
      check("cal ok", 32'(st[ST_CAL_OK]), 32'(e == ERR_NONE));
      check("alarm flag", 32'(st[ST_ALARM]), 32'(e != ERR_NONE));
      check("error code", 32'(st[ST_ERR_LSB +: 8]), 32'(e));
      // Lets the blink run whole halves before the next request
      repeat (4 * BLN) @(posedge aclk);
      $display("test calibration verdict %h done", v);
   endtask

   always @(posedge aclk)
   begin
      cyc++;
      if (cyc == LIMIT)
      begin
         mismatches++;
         close_out;
      end
   end

   initial
   begin
      void'($urandom(32'h5929));
      aresetn = 1'b0;
      ce = 1'b1;
      node_sw = 8'($urandom());
      range_sw = SW_SERVICE_POS;
      svc_sel = 4'($urandom_range(8, 0));
      svc_changed = 1'b1;
      repeat (2) @(posedge aclk);
      aresetn <= 1'b1;
      exp_node = {8'h00, node_sw};
      repeat (6) @(posedge aclk);
      check("boot cal_led", 32'(cal_led), 32'h1);
      check("boot alarm_led", 32'(alarm_led), 32'h1);
      check("run_led dark", 32'(fieldbus_run_led), 32'h0);
      check("fault_led dark", 32'(fieldbus_fault_led), 32'h0);
      node_sw <= ~node_sw;
      repeat (CLN + CAN + 10) @(posedge aclk);
      check("node_id", 32'(node_id), 32'(exp_node));
      check("idle cal_led", 32'(cal_led), 32'h0);
      check("idle alarm_led", 32'(alarm_led), 32'h0);
      wait_lvl(1'b1, k);
      wait_lvl(1'b0, a);
      wait_lvl(1'b1, b);
      check("pulse period", 32'(a + b), 32'(PRN));
      $display("test boot done");
      wr(A_CTRL, 32'h4);
      repeat (3) @(posedge aclk);
      check("run_led on", 32'(fieldbus_run_led), 32'h1);
      rd(A_STATUS);
      check("sel service", 32'(st[ST_SEL_LSB +: 4]), 32'(svc_sel));
      pv = 4'($urandom_range(8, 0));
      wr(A_PARAM, {27'h0, 1'b1, pv});
      rd(A_STATUS);
      check("sel param", 32'(st[ST_SEL_LSB +: 4]), 32'(pv));
      rd(8'h40);
      check("unmapped resp", 32'(rr), 32'(RESP_SLVERR));
      check("unmapped data", st, RD_ZERO);
      $display("test bus and range done");
      for (int i = 0; i < 4; i++)
         run_cal(vd[i], ve[i]);
      sp = 10'($urandom_range(1023, 1));
      wr(A_CTRL, {6'h00, sp, 16'h0006});
      repeat (3) @(posedge aclk);
      check("heat refused", 32'(heat_led), 32'h0);
      run_cal(32'h1, ERR_NONE);
      wr(A_CTRL, {6'h00, sp, 16'h0006});
      repeat (3) @(posedge aclk);
      check("heat_led", 32'(heat_led), 32'h1);
      rd(A_STATUS);
      check("control active", 32'(st[ST_CTRL_ACT]), 32'h1);
      $display("test heat done");
      close_out;
   end
endmodule

bind scs_seq scs_seq_asserts #(.PULSE_N(PULSE_N), .BLINK_N(BLINK_N)) u_scs_seq_asserts (
   .aclk, .aresetn, .cal_led, .alarm_led, .output_led, .heat_led, .fieldbus_fault_led, .node_id
);
